/* File: hdl/bbx_cfg.svh */
// constants for the byte and bit operation execute unit
`ifndef BBX_CFG_SVH
`define BBX_CFG_SVH

// opcode fields, upper six bits of byte-oriented words
`define BBX_ENC_ADD 6'h07
`define BBX_ENC_AND 6'h05
// opcode fields, upper four bits of bit-oriented words
`define BBX_ENC_BCLR 4'h4
`define BBX_ENC_BSET 4'h5
`define BBX_ENC_BTSZ 4'h6

// no-operation word: 00 0000 0xx0 0000
`define BBX_NOP_MASK 14'h3F9F
`define BBX_NOP_VAL 14'h0000

// field positions inside the instruction word
`define BBX_DEST_POS 7
`define BBX_BIT_LSB 7
`define BBX_ADDR_MSB 6

// file addresses whose operand is read from the pins
`define BBX_IO_ADDR_A 7'h05
`define BBX_IO_ADDR_B 7'h06

// reset values
`define BBX_ACC_RST 8'h00
`define BBX_FLAG_RST 1'h0

`endif

/* File: hdl/bbx_pkg.sv */
// types shared by the execute unit and its decoder
package bbx_pkg;

    typedef enum logic [2:0] {
        BBX_OP_NONE,
        BBX_OP_ADD,
        BBX_OP_AND,
        BBX_OP_BCLR,
        BBX_OP_BSET,
        BBX_OP_BTSZ,
        BBX_OP_NOP,
        BBX_OP_OTHER
    } bbx_op_t;

    typedef struct packed {
        bbx_op_t op;
        logic dest_file;
        logic [2:0] bit_sel;
        logic [6:0] addr;
    } bbx_dec_t;

    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } bbx_wr_t;

    typedef struct packed {
        logic s1_valid;
        logic s1_annul;
        bbx_dec_t s1;
        logic skip_pend;
        logic [7:0] acc;
        logic carry;
        logic digit_carry_flag;
        logic zero;
        bbx_wr_t wr;
        logic rd_en;
        logic skip;
        logic done;
        logic done_nop;
        logic foreign;
    } bbx_state_t;

endpackage : bbx_pkg

/* File: hdl/bbx_decode.sv */
// instruction word decoder for the execute unit
`timescale 1ns/1ps
`include "bbx_cfg.svh"

module bbx_decode
    import bbx_pkg::*;
(
    input wire logic [13:0] instr,
    output bbx_dec_t dec
);

    always_comb begin
        dec = '0;
        dec.dest_file = instr[`BBX_DEST_POS];
        dec.bit_sel = instr[`BBX_BIT_LSB+2:`BBX_BIT_LSB];
        dec.addr = instr[`BBX_ADDR_MSB:0];
        if (instr[13:8] == `BBX_ENC_ADD) begin
            dec.op = BBX_OP_ADD;
        end else if (instr[13:8] == `BBX_ENC_AND) begin
            dec.op = BBX_OP_AND;
        end else if (instr[13:10] == `BBX_ENC_BCLR) begin
            dec.op = BBX_OP_BCLR;
        end else if (instr[13:10] == `BBX_ENC_BSET) begin
            dec.op = BBX_OP_BSET;
        end else if (instr[13:10] == `BBX_ENC_BTSZ) begin
            dec.op = BBX_OP_BTSZ;
        end else if ((instr & `BBX_NOP_MASK) == `BBX_NOP_VAL) begin
            dec.op = BBX_OP_NOP;
        end else begin
            // left to the rest of the core
            dec.op = BBX_OP_OTHER;
        end
    end

endmodule : bbx_decode

/* File: hdl/bbx_exec.sv */
// byte add/and and bit clear/set/test execute unit
// Functional notes
// - the add word 00 0111 dfff ffff adds the accumulator to file register f (0..127) in one cycle and sets C, DC, Z.
// - on add and and, destination bit 0 sends the result to the accumulator and 1 writes it back to the file register.
// - the and word forms accumulator AND file register in one cycle and touches only the zero flag.
// - bit clear forces bit b (0..7) of the file register to zero in one cycle with all flags kept.
// - bit set forces bit b (0..7) of the file register to one in one cycle with all flags kept.
// - bit test skips the next instruction when bit b of the file register is zero and keeps all flags.
// - on a skip the already fetched instruction is dropped and executed as a no-operation, so the test takes two cycles.
// - a read-modify-write of a port register takes its operand from the pin levels, not the output latch.
`timescale 1ns/1ps
`include "bbx_cfg.svh"

module bbx_exec
    import bbx_pkg::*;
#(
    parameter logic [6:0] IO_ADDR_A = `BBX_IO_ADDR_A,
    parameter logic [6:0] IO_ADDR_B = `BBX_IO_ADDR_B
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] pin_rdata,
    output logic file_rd_en,
    output logic [6:0] file_rd_addr,
    output bbx_wr_t file_wr,
    output logic [7:0] acc,
    output logic carry,
    output logic digit_carry_flag,
    output logic zero,
    output logic skip,
    output logic done,
    output logic done_nop,
    output logic foreign
);

    ////////////////////////////////////////////////////////////////////////
    // decode and operand selection

    bbx_dec_t dec_in;
    bbx_state_t st;
    bbx_state_t next_st;
    logic is_port;
    logic [7:0] opnd;
    logic [7:0] bit_mask;
    logic [8:0] sum9;
    logic [4:0] half;
    logic [7:0] and_res;
    logic exec;

    bbx_decode u_decode (
        .instr(instr),
        .dec(dec_in)
    );

    assign exec = st.s1_valid && !st.s1_annul;
    assign is_port = (st.s1.addr == IO_ADDR_A) || (st.s1.addr == IO_ADDR_B);
    assign bit_mask = 8'h01 << st.s1.bit_sel;

    always_comb begin
        if (is_port) begin
            // pins, not latch: an input pin pulled low writes back a zero
            opnd = pin_rdata;
        end else if (st.wr.en && st.wr.addr == st.s1.addr) begin
            // the write issued last cycle lands only at the next edge
            opnd = st.wr.data;
        end else begin
            opnd = file_rdata;
        end
    end

    assign sum9 = {1'b0, st.acc} + {1'b0, opnd};
    assign half = {1'b0, st.acc[3:0]} + {1'b0, opnd[3:0]};
    assign and_res = st.acc & opnd;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;
        next_st.wr.en = 1'b0;
        next_st.skip = 1'b0;
        next_st.done = 1'b0;
        next_st.done_nop = 1'b0;
        next_st.foreign = 1'b0;
        if (st.s1_valid) begin
            next_st.done = 1'b1;
            next_st.done_nop = st.s1_annul;
        end
        if (exec) begin
            unique case (st.s1.op)
                BBX_OP_ADD: begin
                    next_st.carry = sum9[8];
                    next_st.digit_carry_flag = half[4];
                    next_st.zero = (sum9[7:0] == 8'h00);
                    if (st.s1.dest_file) begin
                        next_st.wr = '{en: 1'b1, addr: st.s1.addr, data: sum9[7:0]};
                    end else begin
                        next_st.acc = sum9[7:0];
                    end
                end
                BBX_OP_AND: begin
                    next_st.zero = (and_res == 8'h00);
                    if (st.s1.dest_file) begin
                        next_st.wr = '{en: 1'b1, addr: st.s1.addr, data: and_res};
                    end else begin
                        next_st.acc = and_res;
                    end
                end
                BBX_OP_BCLR: begin
                    next_st.wr = '{en: 1'b1, addr: st.s1.addr, data: opnd & ~bit_mask};
                end
                BBX_OP_BSET: begin
                    next_st.wr = '{en: 1'b1, addr: st.s1.addr, data: opnd | bit_mask};
                end
                BBX_OP_BTSZ: begin
                    next_st.skip = ((opnd & bit_mask) == 8'h00);
                end
                BBX_OP_OTHER: begin
                    next_st.foreign = 1'b1;
                end
                BBX_OP_NONE, BBX_OP_NOP: begin
                end
            endcase
        end
        // the fetch stream never stalls; each valid word moves into stage one
        if (instr_valid) begin
            next_st.s1_valid = 1'b1;
            next_st.s1 = dec_in;
            // the word fetched while a skip resolves becomes a no-operation
            next_st.s1_annul = next_st.skip || st.skip_pend;
            next_st.skip_pend = 1'b0;
        end else begin
            next_st.s1_valid = 1'b0;
            next_st.s1_annul = 1'b0;
            // a skip with a gap in the stream drops the next word that arrives
            next_st.skip_pend = next_st.skip || st.skip_pend;
        end
        next_st.rd_en = next_st.s1_valid && !next_st.s1_annul;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.acc <= `BBX_ACC_RST;
            st.carry <= `BBX_FLAG_RST;
            st.digit_carry_flag <= `BBX_FLAG_RST;
            st.zero <= `BBX_FLAG_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign file_rd_en = st.rd_en;
    assign file_rd_addr = st.s1.addr;
    assign file_wr = st.wr;
    assign acc = st.acc;
    assign carry = st.carry;
    assign digit_carry_flag = st.digit_carry_flag;
    assign zero = st.zero;
    assign skip = st.skip;
    assign done = st.done;
    assign done_nop = st.done_nop;
    assign foreign = st.foreign;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_add_acc: assert property (
        exec && st.s1.op == BBX_OP_ADD && !st.s1.dest_file |=> st.acc == $past(sum9[7:0]) && !st.wr.en
    ) else $error("add to accumulator gave a wrong result");

    chk_dest_file: assert property (
        exec && (st.s1.op == BBX_OP_ADD || st.s1.op == BBX_OP_AND) && st.s1.dest_file
        |=> st.wr.en && st.wr.addr == $past(st.s1.addr) && $stable(st.acc)
    ) else $error("file destination not written or accumulator disturbed");

    chk_and_flags: assert property (
        exec && st.s1.op == BBX_OP_AND
        |=> $stable(st.carry) && $stable(st.digit_carry_flag) && st.zero == ($past(and_res) == 8'h00)
    ) else $error("and touched the wrong flags");

    chk_bit_clear: assert property (
        exec && st.s1.op == BBX_OP_BCLR
        |=> st.wr.en && st.wr.data == ($past(opnd) & ~$past(bit_mask))
            && $stable({st.carry, st.digit_carry_flag, st.zero})
    ) else $error("bit clear wrote a wrong value or changed a flag");

    chk_bit_set: assert property (
        exec && st.s1.op == BBX_OP_BSET
        |=> st.wr.en && st.wr.data == ($past(opnd) | $past(bit_mask))
            && $stable({st.carry, st.digit_carry_flag, st.zero})
    ) else $error("bit set wrote a wrong value or changed a flag");

    chk_skip_decision: assert property (
        exec && st.s1.op == BBX_OP_BTSZ
        |=> st.skip == ($past(opnd[st.s1.bit_sel]) == 1'b0) && !st.wr.en
            && $stable({st.carry, st.digit_carry_flag, st.zero})
    ) else $error("bit test skip decision wrong");

    // the word already fetched sits in stage one while the skip pulse stands
    chk_skip_annul: assert property (
        st.skip && st.s1_valid |-> st.s1_annul && !st.rd_en ##1 st.done && st.done_nop && !st.wr.en
    ) else $error("fetched word after a skip was not turned into a no-operation");

    chk_port_pins: assert property (
        exec && is_port && st.s1.op == BBX_OP_BSET
        |=> st.wr.data == ($past(pin_rdata) | $past(bit_mask))
    ) else $error("port bit set did not start from the pin levels");

    chk_add_flags: assert property (
        exec && st.s1.op == BBX_OP_ADD
        |=> st.carry == $past(sum9[8]) && st.digit_carry_flag == $past(half[4])
            && st.zero == ($past(sum9[7:0]) == 8'h00)
    ) else $error("add flags wrong");

    cov_add_carry: cover property (exec && st.s1.op == BBX_OP_ADD && sum9[8]);
    cov_skip_taken: cover property (st.skip && st.s1_annul ##1 st.done_nop);
    cov_port_bitset: cover property (exec && is_port && st.s1.op == BBX_OP_BSET);
    cov_forward: cover property (exec && st.wr.en && st.wr.addr == st.s1.addr && !is_port);

endmodule : bbx_exec

/* File: hdl/bbx_exec_dummy_guard.sv */
// no logic of its own; nothing in here is instantiated
`timescale 1ns/1ps

/* File: verif/bbx_file_model.sv */
// file register space model on the far side of the execute unit
`timescale 1ns/1ps

module bbx_file_model
    import bbx_pkg::*;
(
    input wire logic clk,
    input wire logic file_rd_en,
    input wire logic [6:0] file_rd_addr,
    input wire bbx_wr_t file_wr,
    output logic [7:0] file_rdata
);
    logic [7:0] mem [128];
    ////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i) * 8'h25 ^ 8'h5A;
        end
    end
    // outside a read cycle the bus shows a changed value, so a late sample cannot pass by luck
    assign file_rdata = file_rd_en ? mem[file_rd_addr] : ~mem[file_rd_addr];
    always @(posedge clk) begin
        if (file_wr.en === 1'b1) begin
            mem[file_wr.addr] <= file_wr.data;
        end
    end
endmodule : bbx_file_model

/* File: verif/tb_top.sv */
// self-checking bench for the execute unit
`timescale 1ns/1ps
`include "bbx_cfg.svh"

module tb_top
    import bbx_pkg::*;
;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
    typedef struct packed {
        logic [7:0] acc; logic [2:0] fl; logic we; logic [6:0] wa;
        logic [7:0] wd; logic sk; logic no_operation; logic fo;
    } bbx_exp_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0] pin_rdata = 8'h00;
    logic [7:0] file_rdata, acc, m_acc;
    logic file_rd_en, carry, digit_carry_flag, zero, skip, done, done_nop, foreign, pend;
    logic [6:0] file_rd_addr;
    bbx_wr_t file_wr;
    logic [2:0] m_fl;
    logic [7:0] sh [128];
    logic [31:0] seed = 32'h0000_0037;
    bbx_exp_t q [$];
    bbx_exp_t ex;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////
    bbx_exec dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
        .pin_rdata(pin_rdata), .file_rd_en(file_rd_en), .file_rd_addr(file_rd_addr), .file_wr(file_wr),
        .acc(acc), .carry(carry), .digit_carry_flag(digit_carry_flag), .zero(zero), .skip(skip),
        .done(done), .done_nop(done_nop), .foreign(foreign));
    bbx_file_model far (.clk(clk), .file_rd_en(file_rd_en), .file_rd_addr(file_rd_addr),
        .file_wr(file_wr), .file_rdata(file_rdata));
    initial begin
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // low and high file addresses only, so reads often follow writes to the same place
    function automatic logic [13:0] rword();
        logic [31:0] r;
        logic [6:0] fa;
        r = rnd();
        fa = {r[3] ? 4'hF : 4'h0, r[2:0]};
        case (r[18:16])
            3'h0: return {`BBX_ENC_ADD, r[7], fa};
            3'h7: return {7'h00, r[6:5], 5'h00};
            3'h1: return {`BBX_ENC_AND, r[7], fa};
            3'h2: return {`BBX_ENC_BCLR, r[10:8], fa};
            3'h3: return {`BBX_ENC_BSET, r[10:8], fa};
            3'h6: return {6'h3E, r[7:0]};
            default: return {`BBX_ENC_BTSZ, r[10:8], fa};
        endcase
    endfunction : rword
    task automatic issue(input logic [13:0] w);
        bbx_exp_t e;
        logic [7:0] o;
        logic [8:0] s;
        e = '0;
        e.wa = w[6:0];
        o = (w[6:0] == 7'h05 || w[6:0] == 7'h06) ? pin_rdata : sh[w[6:0]];
        if (pend) begin
            e.no_operation = 1'b1;
            pend = 1'b0;
        end else if (w[13:8] == `BBX_ENC_ADD || w[13:8] == `BBX_ENC_AND) begin
            s = (w[13:8] == `BBX_ENC_ADD) ? {1'b0, m_acc} + {1'b0, o} : {1'b0, m_acc & o};
            if (w[13:8] == `BBX_ENC_ADD) begin
                m_fl[2:1] = {s[8], ({1'b0, m_acc[3:0]} + {1'b0, o[3:0]}) > 5'h0F};
            end
            m_fl[0] = (s[7:0] == 8'h00);
            e.we = w[7];
            e.wd = s[7:0];
            if (!w[7]) m_acc = s[7:0];
        end else if (w[13:10] == `BBX_ENC_BCLR || w[13:10] == `BBX_ENC_BSET) begin
            e.we = 1'b1;
            e.wd = o;
            e.wd[w[9:7]] = (w[13:10] == `BBX_ENC_BSET);
        end else if (w[13:10] == `BBX_ENC_BTSZ) begin
            e.sk = ~o[w[9:7]];
            pend = e.sk;
        end else if ((w & `BBX_NOP_MASK) != `BBX_NOP_VAL) e.fo = 1'b1;
        if (e.we) sh[w[6:0]] = e.wd;
        e.acc = m_acc;
        e.fl = m_fl;
        q.push_back(e);
        instr_valid = 1'b1;
        instr = w;
        @(posedge clk);
        #1;
    endtask : issue
    // pins change only once the last operand read is over
    task automatic idle(input int n);
        instr_valid = 1'b0;
        instr = 14'(rnd());
        for (int k = 0; k < n; k++) begin
            if (k == 1) pin_rdata = 8'(rnd());
            @(posedge clk);
            #1;
        end
    endtask : idle
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        #2;
        if (done === 1'b1) begin
            ex = (q.size() > 0) ? q.pop_front() : '1;
            `CHK("acc", ex.acc, acc)
            `CHK("flags", ex.fl, {carry, digit_carry_flag, zero})
            `CHK("write_en", ex.we, file_wr.en)
            if (ex.we) `CHK("write", {ex.wa, ex.wd}, {file_wr.addr, file_wr.data})
            `CHK("skip", ex.sk, skip)
            `CHK("annul", {ex.no_operation, ex.fo}, {done_nop, foreign})
        end else if (!rst) `CHK("stray", 2'b00, {file_wr.en, skip})
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        for (int i = 0; i < 128; i++) sh[i] = 8'(i) * 8'h25 ^ 8'h5A;
        m_acc = 8'h00;
        m_fl = 3'h0;
        pend = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        @(posedge clk);
        #1;
        issue({`BBX_ENC_ADD, 1'b0, 7'h7F});
        issue(14'h0040);
        issue({`BBX_ENC_BCLR, 3'h3, 7'h21});
        issue({`BBX_ENC_BTSZ, 3'h3, 7'h21});
        issue({`BBX_ENC_BTSZ, 3'h3, 7'h21});
        issue({`BBX_ENC_ADD, 1'b1, 7'h21});
        issue({`BBX_ENC_BTSZ, 3'h3, 7'h21});
        idle(3);
        issue({`BBX_ENC_ADD, 1'b1, 7'h7F});
        idle(3);
        $display("test directed skip finished");
        for (int i = 0; i < 900; i++) begin
            issue(rword());
            if (rnd() % 8 == 0) idle(2 + int'(rnd() % 3));
        end
        idle(4);
        `CHK("pending", 0, q.size())
        $display("test random stream finished");
        finish_test();
    end
endmodule : tb_top
